// ---- core/bcs_pkg.sv ----
// Package: constants and types for the boot and clock mode sequencer
package bcs_pkg;

  // ****************************************************************
  // Boot timing
  // ****************************************************************
  localparam int BOOT_CYCLES = 8192;
  localparam int PLL_LOCK_TIME_US = 3000;
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_US * 1000) / CLOCK_PERIOD_NS;

  // ****************************************************************
  // Memory geometry and default routing
  // ****************************************************************
  localparam int PROG_DEPTH = 1024;
  localparam int PARAM_DEPTH = 1024;
  localparam int DATA_DEPTH = 6144;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_OUTPUTS = 16;

  // ****************************************************************
  // Clock mode encodings and core ratio
  // ****************************************************************
  typedef enum logic [4:0] {
    BCS_RATIO_64 = 5'h01,
    BCS_RATIO_256 = 5'h02,
    BCS_RATIO_384 = 5'h04,
    BCS_RATIO_512 = 5'h08,
    BCS_BYPASS = 5'h10
  } bcs_clk_mode_t;
  localparam logic [10:0] CORE_RATIO = 11'h600;

  typedef enum logic [2:0] {
    BCS_ST_RESET = 3'h1,
    BCS_ST_BOOT = 3'h2,
    BCS_ST_RUN = 3'h4
  } bcs_state_t;

endpackage : bcs_pkg

// ---- core/bcs_mode_decode.sv ----
// Module: clock mode pin decoder and PLL multiplier selection
`timescale 1ns/1ps
module bcs_mode_decode
  import bcs_pkg::*;
(
  input wire logic [2:0] mode_pins,
  output bcs_clk_mode_t mode,
  output logic [9:0] pll_mult
);

  // ****************************************************************
  // Pin decode; bit0 high wins regardless of upper bits
  // ****************************************************************
  assign mode = mode_pins[0] ? BCS_RATIO_384 :
                (mode_pins[2:1] == 2'h0) ? BCS_RATIO_64 :
                (mode_pins[2:1] == 2'h1) ? BCS_RATIO_256 :
                (mode_pins[2:1] == 2'h2) ? BCS_RATIO_512 :
                BCS_BYPASS;

  // Core clock is 1536 fs, so multiplier is 1536 over the input ratio
  assign pll_mult = (mode == BCS_RATIO_64) ? 10'h018 :
                    (mode == BCS_RATIO_256) ? 10'h006 :
                    (mode == BCS_RATIO_384) ? 10'h004 :
                    (mode == BCS_RATIO_512) ? 10'h003 :
                    10'h001;

endmodule : bcs_mode_decode

// ---- core/bcs_boot_sequencer.sv ----
// Module: reset-release boot sequencer with clock mode capture
//
// Summary of operation
// - Boot copies program ROM and parameter ROM
// - Boot clears all data memory
// - Default program routes eight inputs to sixteen
// - Boot starts on reset rise, 8192 cycles
// - Clock mode latched from pins leaving reset
// - Reset release synchronised on falling edge
// - PLL makes core clock 1536 fs
// - Mode pins decode to ratio or bypass
// - Bypass feeds master clock straight to core
`timescale 1ns/1ps
module bcs_boot_sequencer
  import bcs_pkg::*;
#(
  parameter int BOOT_LEN = BOOT_CYCLES,
  parameter int LOCK_LEN = PLL_LOCK_CYCLES
)(
  input wire logic clock,
  input wire logic nrst,
  input wire logic active_low_reset_pin,
  input wire logic clock_mode_select_bit0,
  input wire logic clock_mode_select_bit1,
  input wire logic clock_mode_select_bit2,
  output logic boot_busy,
  output logic boot_done,
  output logic pll_locked,
  output logic core_clk_bypass,
  output logic [4:0] clk_mode,
  output logic [9:0] pll_mult,
  output logic prog_we,
  output logic [9:0] prog_addr,
  output logic [31:0] prog_wdata,
  output logic param_we,
  output logic [9:0] param_addr,
  output logic [27:0] param_wdata,
  output logic data_we,
  output logic [12:0] data_addr,
  output logic [3:0] route_sel [NUM_OUTPUTS]
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  // Every data word is cleared once, and the step counter is 16 bits
  if (BOOT_LEN < DATA_DEPTH || BOOT_LEN > 65535) begin : g_bad_boot
    $error("bcs_boot_sequencer: BOOT_LEN out of range");
  end
  // The lock counter is 22 bits wide
  if (LOCK_LEN < 1 || LOCK_LEN > 4194303) begin : g_bad_lock
    $error("bcs_boot_sequencer: LOCK_LEN out of range");
  end

  // ****************************************************************
  // Boot ROM images (default program is a pass-through)
  // ****************************************************************
  logic [31:0] prog_rom [PROG_DEPTH];
  logic [27:0] param_rom [PARAM_DEPTH];
  always_comb begin
    for (int i = 0; i < PROG_DEPTH; i++) begin
      prog_rom[i] = 32'h0000_0000;
    end
    prog_rom[0] = 32'h0000_0001;
    for (int i = 0; i < PARAM_DEPTH; i++) begin
      param_rom[i] = 28'h000_0000;
    end
  end

  // ****************************************************************
  // Reset release, caught on the falling clock edge
  // ****************************************************************
  // Falling-edge capture keeps release away from rising-edge logic
  logic rst_fall_q;
  logic rst_sync_q;
  logic rst_prev_q;
  always_ff @(negedge clock) begin
    rst_fall_q <= active_low_reset_pin;
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rst_sync_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end else begin
      rst_sync_q <= rst_fall_q;
      rst_prev_q <= rst_sync_q;
    end
  end
  wire rst_rise = rst_sync_q && !rst_prev_q;
  wire rst_low = !rst_sync_q;

  // ****************************************************************
  // Clock mode decode
  // ****************************************************************
  bcs_clk_mode_t mode_w;
  logic [9:0] mult_w;
  bcs_mode_decode u_dec (
    .mode_pins({clock_mode_select_bit2, clock_mode_select_bit1,
                clock_mode_select_bit0}),
    .mode(mode_w),
    .pll_mult(mult_w)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  bcs_state_t state_q;
  bcs_state_t state_d;
  logic [15:0] cnt_q;
  logic [21:0] lock_q;
  wire boot_last = (cnt_q == 16'(BOOT_LEN - 1));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BCS_ST_RESET: begin
        if (rst_rise) state_d = BCS_ST_BOOT;
      end
      BCS_ST_BOOT: begin
        if (rst_low) state_d = BCS_ST_RESET;
        else if (boot_last) state_d = BCS_ST_RUN;
      end
      BCS_ST_RUN: begin
        if (rst_low) state_d = BCS_ST_RESET;
      end
      default: state_d = BCS_ST_RESET;
    endcase
  end

  // Writes are issued from the next count so that each strobe stands
  // inside the boot_busy window, which is registered from state_d too;
  // driving them from cnt_q would leave the last clear after busy fell
  function automatic logic below_depth(input logic [15:0] idx,
    input int depth);
    return idx < 16'(depth);
  endfunction : below_depth
  wire in_boot = (state_q == BCS_ST_BOOT);
  wire boot_next = (state_d == BCS_ST_BOOT);
  wire [15:0] cnt_d = in_boot ? cnt_q + 16'h0001 : 16'h0000;
  wire prog_hit = boot_next && below_depth(cnt_d, PROG_DEPTH);
  wire param_hit = boot_next && below_depth(cnt_d, PARAM_DEPTH);
  wire data_hit = boot_next && below_depth(cnt_d, DATA_DEPTH);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= BCS_ST_RESET;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // Memory load and clear strobes
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prog_we <= 1'b0;
      prog_addr <= 10'h000;
      prog_wdata <= 32'h0000_0000;
      param_we <= 1'b0;
      param_addr <= 10'h000;
      param_wdata <= 28'h000_0000;
      data_we <= 1'b0;
      data_addr <= 13'h0000;
    end else begin
      prog_we <= prog_hit;
      prog_addr <= cnt_d[9:0];
      prog_wdata <= prog_rom[cnt_d[9:0]];
      param_we <= param_hit;
      param_addr <= cnt_d[9:0];
      param_wdata <= param_rom[cnt_d[9:0]];
      data_we <= data_hit;
      data_addr <= cnt_d[12:0];
    end
  end

  // ****************************************************************
  // Status, clock mode and PLL lock
  // ****************************************************************
  // Mode is frozen while running; pin moves then need a reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      boot_busy <= 1'b0;
      boot_done <= 1'b0;
      clk_mode <= 5'h01;
      pll_mult <= 10'h018;
      core_clk_bypass <= 1'b0;
      lock_q <= 22'h00_0000;
      pll_locked <= 1'b0;
    end else begin
      boot_busy <= boot_next;
      boot_done <= (state_d == BCS_ST_RUN);
      if (rst_low || rst_rise) begin
        clk_mode <= mode_w;
        pll_mult <= mult_w;
        core_clk_bypass <= (mode_w == BCS_BYPASS);
      end
      // Host must hold off until this rises
      if (rst_low) lock_q <= 22'h00_0000;
      else if (lock_q != 22'(LOCK_LEN)) lock_q <= lock_q + 22'h00_0001;
      pll_locked <= !rst_low && (lock_q == 22'(LOCK_LEN));
    end
  end

  // ****************************************************************
  // Default routing: output k takes input k mod 8
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_route
      always_ff @(posedge clock) begin
        if (!nrst) route_sel[g] <= 4'h0;
        else if (in_boot) route_sel[g] <= 4'(g % NUM_INPUTS);
      end
    end
  endgenerate

endmodule : bcs_boot_sequencer

// ---- verification/bcs_asserts.sv ----
// Checker: port assertions for the boot sequencer
`timescale 1ns/1ps
module bcs_asserts
  import bcs_pkg::*;
#(
  parameter int BOOT_LEN = BOOT_CYCLES
)(
  input wire logic clock,
  input wire logic nrst,
  input wire logic active_low_reset_pin,
  input wire logic boot_busy,
  input wire logic boot_done,
  input wire logic pll_locked,
  input wire logic core_clk_bypass,
  input wire logic [4:0] clk_mode,
  input wire logic [9:0] pll_mult,
  input wire logic prog_we,
  input wire logic data_we,
  input wire logic [3:0] route_sel [NUM_OUTPUTS]
);
  // ****
  // Busy length counter
  // ****
  logic [15:0] busy_cnt_q;
  always_ff @(posedge clock) begin
    busy_cnt_q <= boot_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_boot_starts: assert property ($rose(active_low_reset_pin) |->
    ##[1:5] boot_busy) else $error("boot did not start");
  a_boot_length: assert property ($fell(boot_busy) &&
    active_low_reset_pin |-> busy_cnt_q == BOOT_LEN)
    else $error("boot length wrong");
  a_done_follows: assert property ($fell(boot_busy) &&
    active_low_reset_pin |-> boot_done) else $error("no done");
  a_busy_done_excl: assert property (!(boot_busy && boot_done))
    else $error("busy and done together");
  a_writes_in_boot: assert property ((prog_we || data_we) |->
    boot_busy) else $error("memory write outside boot");
  a_pin_low_stops: assert property (!active_low_reset_pin [*3] |=>
    !boot_busy && !boot_done) else $error("pin low ignored");
  a_mode_held: assert property (boot_done |-> $stable(clk_mode))
    else $error("mode moved while running");
  a_mult_matches: assert property ((clk_mode == 5'h01 &&
    pll_mult == 10'h018) || (clk_mode == 5'h02 && pll_mult == 10'h006)
    || (clk_mode == 5'h04 && pll_mult == 10'h004) || (clk_mode == 5'h08
    && pll_mult == 10'h003) || (clk_mode == 5'h10 && pll_mult == 10'h001))
    else $error("ratio and multiplier disagree");
  a_bypass_flag: assert property (core_clk_bypass ==
    (clk_mode == 5'h10)) else $error("bypass flag wrong");
  a_route_default: assert property (boot_done |-> route_sel[15] == 4'h7
    && route_sel[3] == 4'h3 && route_sel[8] == 4'h0)
    else $error("default routing wrong");
  c_boot_end: cover property ($fell(boot_busy));
  c_bypass_run: cover property (core_clk_bypass && boot_done);
  c_lock: cover property ($rose(pll_locked));
endmodule : bcs_asserts
bind bcs_boot_sequencer bcs_asserts #(.BOOT_LEN(BOOT_LEN)) u_chk (
  .clock, .nrst, .active_low_reset_pin, .boot_busy, .boot_done,
  .pll_locked, .core_clk_bypass, .clk_mode, .pll_mult, .prog_we,
  .data_we, .route_sel);

// ---- verification/bcs_rst_drv.sv ----
// Partner model: system reset driver and mode pin strapping
`timescale 1ns/1ps
module bcs_rst_drv (
  input wire logic clock,
  input wire logic release_req,
  input wire logic careless,
  input wire logic [2:0] mode_req,
  output logic pin_q,
  output logic [2:0] mode_q
);
  initial begin
    pin_q = 1'b0;
    mode_q = 3'h0;
  end
  // Straps move only under reset, unless told to misbehave
  always @(negedge clock) begin
    if (!pin_q || careless) begin
      mode_q <= mode_req;
    end
    pin_q <= release_req;
  end
endmodule : bcs_rst_drv

// ---- verification/testbench.sv ----
// Testbench: boot length, mode decode, strap refusal, restart
`timescale 1ns/1ps
module testbench;
  import bcs_pkg::*;
  localparam int BL = 6144;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic release_req = 1'b0;
  logic careless = 1'b0;
  logic [2:0] mode_req = 3'h0;
  logic pin;
  logic [2:0] mp;
  logic busy, done, lock, byp, pwe, qwe, dwe;
  logic [4:0] cm;
  logic [9:0] pm;
  logic [12:0] da;
  logic [9:0] pa;
  logic [9:0] qa;
  logic [31:0] pd;
  logic [27:0] qd;
  logic [3:0] rs [NUM_OUTPUTS];
  int failures = 0;
  int n_checks = 0;
  logic [2:0] mtab [8] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h5, 3'h7, 3'h4, 3'h6};
  logic [4:0] etab [8] = '{5'h01, 5'h02, 5'h04, 5'h04, 5'h04, 5'h04,
    5'h08, 5'h10};
  initial begin
    forever #4 clock = ~clock;
  end
  bcs_rst_drv u_drv (.clock(clock), .release_req(release_req),
    .careless(careless), .mode_req(mode_req), .pin_q(pin), .mode_q(mp));
  bcs_boot_sequencer #(.BOOT_LEN(BL), .LOCK_LEN(16)) u_dut (
    .clock(clock), .nrst(nrst), .active_low_reset_pin(pin),
    .clock_mode_select_bit0(mp[0]), .clock_mode_select_bit1(mp[1]),
    .clock_mode_select_bit2(mp[2]), .boot_busy(busy), .boot_done(done),
    .pll_locked(lock), .core_clk_bypass(byp), .clk_mode(cm),
    .pll_mult(pm), .prog_we(pwe), .prog_addr(pa), .prog_wdata(pd),
    .param_we(qwe), .param_addr(qa), .param_wdata(qd), .data_we(dwe),
    .data_addr(da), .route_sel(rs));
  task automatic chk(input string nm, input logic [31:0] e, got);
    n_checks++;
    if (got !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic boot_mode(input logic [2:0] m, input logic [4:0] em);
    int nb, np, nq, nd, t, nm, nz, nzp;
    logic [12:0] last;
    logic [9:0] lp;
    logic [9:0] lq;
    nb = 0;
    np = 0;
    nq = 0;
    nd = 0;
    t = 0;
    nm = 0;
    nz = 0;
    nzp = 0;
    last = 13'h0000;
    lp = 10'h000;
    lq = 10'h000;
    @(negedge clock);
    release_req <= 1'b0;
    mode_req <= m;
    repeat (5) @(negedge clock);
    chk("lock in reset", 0, lock);
    release_req <= 1'b1;
    while (done !== 1'b1 && t < BL + 100) begin
      @(negedge clock);
      t++;
      nb += int'(busy === 1'b1);
      np += int'(pwe === 1'b1);
      nq += int'(qwe === 1'b1);
      nd += int'(dwe === 1'b1);
      if (dwe === 1'b1) last = da;
      if (pwe === 1'b1) begin
        lp = pa;
        nm += int'(pa !== da[9:0]);
        nzp += int'(pd !== 32'h0000_0000);
      end
      if (qwe === 1'b1) begin
        lq = qa;
        nz += int'(qd !== 28'h000_0000);
      end
    end
    chk("busy cycles", BL, nb);
    chk("last prog", PROG_DEPTH - 1, lp);
    chk("last param", PARAM_DEPTH - 1, lq);
    chk("prog addr step", 0, nm);
    chk("param image", 0, nz);
    chk("prog image", 1, int'(nzp > 0));
    chk("prog writes", PROG_DEPTH, np);
    chk("param writes", PARAM_DEPTH, nq);
    chk("data clears", DATA_DEPTH, nd);
    chk("last clear", DATA_DEPTH - 1, last);
    chk("mode", em, cm);
    chk("mult", em == 5'h10 ? 1 : 1536 / (em == 5'h01 ? 64 : em == 5'h02 ?
      256 : em == 5'h04 ? 384 : 512), pm);
    chk("bypass", em == 5'h10, byp);
    chk("route 11", 3, rs[11]);
    t = 0;
    while (lock !== 1'b1 && t < 100) begin
      @(negedge clock);
      t++;
    end
    chk("lock", 1, lock);
    $display("boot with straps %b done", m);
  endtask : boot_mode
  task automatic refuse_change();
    careless <= 1'b1;
    mode_req <= 3'h0;
    repeat (8) @(negedge clock);
    chk("mode kept", 5'h10, cm);
    chk("bypass kept", 1, byp);
    careless <= 1'b0;
    $display("strap change while running done");
  endtask : refuse_change
  task automatic restart_boot();
    release_req <= 1'b0;
    repeat (5) @(negedge clock);
    release_req <= 1'b1;
    repeat (100) @(negedge clock);
    chk("busy mid boot", 1, busy);
    boot_mode(3'h4, 5'h08);
    $display("restart mid boot done");
  endtask : restart_boot
  initial begin
    #(8 * 90000);
    failures++;
    $display("[ERR] watchdog expected finish seen hang");
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      boot_mode(mtab[i], etab[i]);
    end
    refuse_change();
    restart_boot();
    wrap_up();
  end
endmodule : testbench
